//--- design/alu_branch_exec.sv
// execution unit for arithmetic, multiply and program-flow operations
// ****
// Notes on behaviour
// - add with/without carry: store sum, update Z C N V H, one cycle
// - word add constant to pair: update Z C N V S, two cycles
// - subtract register/constant, with/without borrow: Z C N V H, one cycle
// - word subtract constant from pair: update Z C N V S, two cycles
// - and/or/xor: store result, update only Z N V, one cycle
// - ones complement is ff minus value; twos is 00 minus value
// - set bits ORs mask, clear bits ANDs inverted mask; Z N V
// - increment, decrement, test: only Z N V, carry kept, one cycle
// - clear is xor with itself; all-ones load keeps every flag
// - multiplies write 16-bit product to r1:r0, update Z C, two cycles
// - fractional multiplies shift product left one, Z C, two cycles
// - relative goto/call: pc plus offset plus one; 2 or 4 cycles
// - pointer goto/call: pc loaded from Z pair; 2 or 4 cycles
// - absolute goto 3 cycles, absolute call 5 cycles
// - equal skip advances pc by 2 or 3, taking 1/2/3 cycles
// - compares subtract without storing, update Z N V C H, one cycle
// - register bit skip tests bit b, skips when condition holds
// - io bit skip tests bit b of io value, skips when holds
// - flag branch taken loads pc plus offset plus one; 1 or 2 cycles
// - signed ge branches on N xor V zero, lt on one
// - unsigned ge/lt test carry; equal tests Z; minus/plus test N
// - half-carry, transfer bit and overflow branches via flag select
// ****
`timescale 1ns/1ps
`default_nettype none
module alu_branch_exec
    import exec_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // request from decode
    input  wire logic        issue,
    input  wire op_e         op,
    input  wire logic [7:0]  rd_val,
    input  wire logic [7:0]  rr_val,
    input  wire logic [7:0]  rd_hi_val,
    input  wire logic [7:0]  imm,
    input  wire logic [2:0]  sel,
    input  wire logic signed [11:0] offset,
    input  wire logic [15:0] abs_addr,
    input  wire logic [15:0] z_ptr,
    input  wire logic [15:0] stack_pc,
    input  wire logic [7:0]  io_val,
    input  wire logic        next_is_long,
    // register file write
    output logic             wr_en,
    output logic [7:0]       wr_lo,
    output logic [7:0]       wr_hi,
    output logic             wr_pair,
    output logic             wr_mul,
    // status and flow
    output logic [7:0]       flags_word,
    output logic [15:0]      pc,
    output logic             busy,
    output logic             done
);
    // ****
    // helpers
    // ****
    function automatic logic [15:0] rel_target(input logic [15:0] p,
                                               input logic signed [11:0] k);
        rel_target = p + 16'({{4{k[11]}}, k}) + 16'h0001;
    endfunction

    logic [7:0]  flags_ff, nxt_flags;
    logic [15:0] pc_ff, nxt_pc;
    logic [2:0]  cnt_ff, nxt_cnt;
    seq_e        st_ff, nxt_st;
    logic        wr_en_ff, wr_pair_ff, wr_mul_ff, done_ff;
    logic [7:0]  wr_lo_ff, wr_hi_ff;
    logic        nxt_wr_en, nxt_wr_pair, nxt_wr_mul;
    logic [7:0]  nxt_wr_lo, nxt_wr_hi;

    // ****
    // operand selection for the adder
    // ****
    wire logic is_sub_op = (op == OP_SUB) || (op == OP_SUB_BORROW) || (op == OP_CMP)
                        || (op == OP_CMP_BORROW) || (op == OP_TWOS_INV)
                        || (op == OP_MINUS_ONE);
    wire logic use_cin   = (op == OP_ADD_CARRY) || (op == OP_SUB_BORROW)
                        || (op == OP_CMP_BORROW);
    wire logic [7:0] alu_a = (op == OP_TWOS_INV) ? ALL_ZERO : rd_val;
    wire logic [7:0] alu_b = (op == OP_TWOS_INV) ? rd_val
                           : (op == OP_PLUS_ONE || op == OP_MINUS_ONE) ? 8'h01 : rr_val;
    wire logic       alu_cin = use_cin & flags_ff[FLAG_C];
    wire logic [7:0] alu_sum;
    wire logic       alu_c, alu_h, alu_v;

    byte_alu u_alu (
        .a     (alu_a),
        .b     (alu_b),
        .cin   (alu_cin),
        .sub   (is_sub_op),
        .sum   (alu_sum),
        .c_out (alu_c),
        .h_out (alu_h),
        .v_out (alu_v)
    );

    // ****
    // multiplier
    // ****
    wire logic mul_as = (op == OP_MUL_S) || (op == OP_MUL_SU)
                     || (op == OP_FRACTION_PRODUCT_UNSIGNED_S) || (op == OP_FRACTION_PRODUCT_UNSIGNED_SU);
    wire logic mul_bs = (op == OP_MUL_S) || (op == OP_FRACTION_PRODUCT_UNSIGNED_S);
    wire logic mul_fr = (op == OP_FRACTION_PRODUCT_UNSIGNED_U) || (op == OP_FRACTION_PRODUCT_UNSIGNED_S) || (op == OP_FRACTION_PRODUCT_UNSIGNED_SU);
    wire logic [15:0] mul_p;
    wire logic        mul_c;

    mul_unit u_mul (
        .a        (rd_val),
        .b        (rr_val),
        .a_signed (mul_as),
        .b_signed (mul_bs),
        .frac     (mul_fr),
        .prod     (mul_p),
        .c_out    (mul_c)
    );

    // ****
    // word add/subtract on the pair
    // ****
    wire logic [15:0] pair    = {rd_hi_val, rd_val};
    wire logic        w_sub   = (op == OP_WORD_DIFF);
    wire logic [15:0] w_res   = w_sub ? pair - {8'h00, imm} : pair + {8'h00, imm};
    wire logic        w_c     = w_sub ? (w_res[15] & ~pair[15]) : (~w_res[15] & pair[15]);
    wire logic        w_v     = w_sub ? (pair[15] & ~w_res[15]) : (~pair[15] & w_res[15]);

    // ****
    // logic results
    // ****
    wire logic [7:0] logic_res =
          (op == OP_AND || op == OP_ZM_CHECK) ? (rd_val & rr_val)
        : (op == OP_OR)                       ? (rd_val | rr_val)
        : (op == OP_MASK_SET)                 ? (rd_val | imm)
        : (op == OP_MASK_CLEAR)               ? (rd_val & (ALL_ONES - imm))
        : (op == OP_ONES_INV)                 ? (ALL_ONES - rd_val)
        : (op == OP_ZERO_REG)                 ? (rd_val ^ rd_val)
        :                                       (rd_val ^ rr_val);

    // ****
    // condition and skip decode
    // ****
    wire logic sel_flag   = flags_ff[sel];
    wire logic nv_xor     = flags_ff[FLAG_N] ^ flags_ff[FLAG_V];
    wire logic br_cond    = (op == OP_FLAG_SET_BRANCH) ?  sel_flag
                          : (op == OP_FLAG_CLR_BRANCH) ? ~sel_flag
                          : (op == OP_SIGNED_GE)       ? ~nv_xor
                          :                               nv_xor;
    wire logic is_branch  = (op == OP_FLAG_SET_BRANCH) || (op == OP_FLAG_CLR_BRANCH)
                         || (op == OP_SIGNED_GE) || (op == OP_SIGNED_LT);
    wire logic skip_cond  = (op == OP_EQUAL_SKIP)       ? (rd_val == rr_val)
                          : (op == OP_REG_BIT_CLR_SKIP) ? ~rr_val[sel]
                          : (op == OP_REG_BIT_SET_SKIP) ?  rr_val[sel]
                          : (op == OP_IO_BIT_CLR_SKIP)  ? ~io_val[sel]
                          :                                io_val[sel];
    wire logic is_skip    = (op == OP_EQUAL_SKIP) || (op == OP_REG_BIT_CLR_SKIP)
                         || (op == OP_REG_BIT_SET_SKIP) || (op == OP_IO_BIT_CLR_SKIP)
                         || (op == OP_IO_BIT_SET_SKIP);
    wire logic [2:0] skip_len = next_is_long ? 3'h3 : 3'h2;

    // ****
    // per-operation effects
    // ****
    always_comb
    begin
        logic [2:0] cyc;
        cyc         = CYC_ONE;
        nxt_flags   = flags_ff;
        nxt_pc      = pc_ff + 16'h0001;
        nxt_wr_en   = 1'b0;
        nxt_wr_pair = 1'b0;
        nxt_wr_mul  = 1'b0;
        nxt_wr_lo   = alu_sum;
        nxt_wr_hi   = ALL_ZERO;
        case (op)
            OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_CMP, OP_CMP_BORROW:
            begin
                nxt_wr_en         = !(op == OP_CMP || op == OP_CMP_BORROW);
                nxt_flags[FLAG_C] = alu_c;
                nxt_flags[FLAG_H] = alu_h;
                nxt_flags[FLAG_V] = alu_v;
                nxt_flags[FLAG_N] = alu_sum[7];
                nxt_flags[FLAG_S] = alu_sum[7] ^ alu_v;
                nxt_flags[FLAG_Z] = (op == OP_SUB_BORROW || op == OP_CMP_BORROW)
                                  ? ((alu_sum == ALL_ZERO) & flags_ff[FLAG_Z]) // chain keeps Z
                                  : (alu_sum == ALL_ZERO);
            end
            OP_TWOS_INV:
            begin
                nxt_wr_en         = 1'b1;
                nxt_flags[FLAG_C] = (alu_sum != ALL_ZERO);
                nxt_flags[FLAG_H] = alu_h;
                nxt_flags[FLAG_V] = (alu_sum == 8'h80);
                nxt_flags[FLAG_N] = alu_sum[7];
                nxt_flags[FLAG_Z] = (alu_sum == ALL_ZERO);
            end
            OP_PLUS_ONE, OP_MINUS_ONE:
            begin
                nxt_wr_en         = 1'b1;
                nxt_flags[FLAG_V] = alu_v;
                nxt_flags[FLAG_N] = alu_sum[7];
                nxt_flags[FLAG_Z] = (alu_sum == ALL_ZERO);
            end
            OP_AND, OP_OR, OP_XOR, OP_MASK_SET, OP_MASK_CLEAR, OP_ZM_CHECK,
            OP_ZERO_REG, OP_ONES_INV:
            begin
                nxt_wr_en         = (op != OP_ZM_CHECK);
                nxt_wr_lo         = logic_res;
                nxt_flags[FLAG_V] = 1'b0;
                nxt_flags[FLAG_N] = logic_res[7];
                nxt_flags[FLAG_Z] = (logic_res == ALL_ZERO);
                if (op == OP_ONES_INV)
                    nxt_flags[FLAG_C] = 1'b1;
            end
            OP_ALL_ONES:
            begin
                nxt_wr_en = 1'b1;
                nxt_wr_lo = ALL_ONES;
            end
            OP_WORD_SUM, OP_WORD_DIFF:
            begin
                cyc               = CYC_WORD;
                nxt_wr_en         = 1'b1;
                nxt_wr_pair       = 1'b1;
                nxt_wr_lo         = w_res[7:0];
                nxt_wr_hi         = w_res[15:8];
                nxt_flags[FLAG_C] = w_c;
                nxt_flags[FLAG_V] = w_v;
                nxt_flags[FLAG_N] = w_res[15];
                nxt_flags[FLAG_S] = w_res[15] ^ w_v;
                nxt_flags[FLAG_Z] = (w_res == 16'h0000);
            end
            OP_MUL_U, OP_MUL_S, OP_MUL_SU, OP_FRACTION_PRODUCT_UNSIGNED_U, OP_FRACTION_PRODUCT_UNSIGNED_S, OP_FRACTION_PRODUCT_UNSIGNED_SU:
            begin
                cyc               = CYC_MUL;
                nxt_wr_en         = 1'b1;
                nxt_wr_mul        = 1'b1;
                nxt_wr_lo         = mul_p[7:0];
                nxt_wr_hi         = mul_p[15:8];
                nxt_flags[FLAG_C] = mul_c;
                nxt_flags[FLAG_Z] = (mul_p == 16'h0000);
            end
            OP_REL_GOTO, OP_REL_CALL:
            begin
                cyc    = (op == OP_REL_GOTO) ? CYC_RELGOTO : CYC_RELCALL;
                nxt_pc = rel_target(pc_ff, offset);
            end
            OP_PTR_GOTO, OP_PTR_CALL:
            begin
                cyc    = (op == OP_PTR_GOTO) ? CYC_PTRGOTO : CYC_PTRCALL;
                nxt_pc = z_ptr;
            end
            OP_ABS_GOTO, OP_ABS_CALL:
            begin
                cyc    = (op == OP_ABS_GOTO) ? CYC_ABSGOTO : CYC_ABSCALL;
                nxt_pc = abs_addr;
            end
            OP_SUB_EXIT, OP_INT_EXIT:
            begin
                cyc    = CYC_RETURN;
                nxt_pc = stack_pc;
                if (op == OP_INT_EXIT)
                    nxt_flags[FLAG_I] = 1'b1;
            end
            default:
            begin
                if (is_skip && skip_cond)
                begin
                    cyc    = skip_len;
                    nxt_pc = pc_ff + {13'h0000, skip_len};
                end
                else if (is_branch && br_cond)
                begin
                    cyc    = CYC_BR_TAKEN;
                    nxt_pc = rel_target(pc_ff, offset);
                end
            end
        endcase
        nxt_cnt = cyc - 3'h1;
    end

    // ****
    // sequencer: results commit in the last cycle of the operation
    // ****
    logic commit;
    always_comb
    begin
        nxt_st = st_ff;
        commit = 1'b0;
        case (st_ff)
            ST_IDLE, ST_DONE:
                if (issue)
                begin
                    commit = (nxt_cnt == 3'h0);
                    nxt_st = commit ? ST_DONE : ST_BUSY;
                end
                else
                    nxt_st = ST_IDLE;
            ST_BUSY:
                if (cnt_ff == 3'h1)
                    nxt_st = ST_DONE;
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    // results are latched at issue so decode may move on while busy
    logic [7:0]  hold_flags_ff, hold_lo_ff, hold_hi_ff;
    logic [15:0] hold_pc_ff;
    logic        hold_en_ff, hold_pair_ff, hold_mul_ff;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff         <= ST_IDLE;
            cnt_ff        <= 3'h0;
            flags_ff      <= FLAGS_RST;
            pc_ff         <= PC_RST;
            hold_flags_ff <= FLAGS_RST;
            hold_pc_ff    <= PC_RST;
            hold_lo_ff    <= ALL_ZERO;
            hold_hi_ff    <= ALL_ZERO;
            {hold_en_ff, hold_pair_ff, hold_mul_ff} <= 3'b000;
        end
        else
        begin
            st_ff <= nxt_st;
            if ((st_ff != ST_BUSY) && issue && !commit)
            begin
                cnt_ff        <= nxt_cnt;
                hold_flags_ff <= nxt_flags;
                hold_pc_ff    <= nxt_pc;
                hold_lo_ff    <= nxt_wr_lo;
                hold_hi_ff    <= nxt_wr_hi;
                {hold_en_ff, hold_pair_ff, hold_mul_ff} <= {nxt_wr_en, nxt_wr_pair, nxt_wr_mul};
            end
            else if (st_ff == ST_BUSY)
                cnt_ff <= cnt_ff - 3'h1;
            if (commit)
            begin
                flags_ff <= nxt_flags;
                pc_ff    <= nxt_pc;
            end
            else if (st_ff == ST_BUSY && cnt_ff == 3'h1)
            begin
                flags_ff <= hold_flags_ff;
                pc_ff    <= hold_pc_ff;
            end
        end
    end

    // ****
    // registered write-back strobes
    // ****
    wire logic fin = (st_ff == ST_BUSY) && (cnt_ff == 3'h1);
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {wr_en_ff, wr_pair_ff, wr_mul_ff, done_ff} <= 4'h0;
            wr_lo_ff <= ALL_ZERO;
            wr_hi_ff <= ALL_ZERO;
        end
        else
        begin
            done_ff    <= commit | fin;
            wr_en_ff   <= commit ? nxt_wr_en   : (fin & hold_en_ff);
            wr_pair_ff <= commit ? nxt_wr_pair : (fin & hold_pair_ff);
            wr_mul_ff  <= commit ? nxt_wr_mul  : (fin & hold_mul_ff);
            wr_lo_ff   <= commit ? nxt_wr_lo   : hold_lo_ff;
            wr_hi_ff   <= commit ? nxt_wr_hi   : hold_hi_ff;
        end
    end

    assign wr_en      = wr_en_ff;
    assign wr_pair    = wr_pair_ff;
    assign wr_mul     = wr_mul_ff;
    assign wr_lo      = wr_lo_ff;
    assign wr_hi      = wr_hi_ff;
    assign flags_word = flags_ff;
    assign pc         = pc_ff;
    assign busy       = st_ff[1]; // one-hot busy bit, no decode gate
    assign done       = done_ff;
endmodule
`default_nettype wire

//--- design/byte_alu.sv
// 8-bit adder/subtractor core with flag generation
`timescale 1ns/1ps
`default_nettype none
module byte_alu
    import exec_pkg::*;
(
    // operands
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    input  wire logic       sub,
    // results
    output logic [7:0]      sum,
    output logic            c_out,
    output logic            h_out,
    output logic            v_out
);
    // ********************************
    // add or subtract with carry/borrow
    // ********************************
    wire logic [7:0] b_eff = sub ? ~b : b;
    wire logic       c_eff = sub ? ~cin : cin;
    wire logic [8:0] full  = {1'b0, a} + {1'b0, b_eff} + {8'h00, c_eff};
    wire logic [4:0] half  = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};

    // borrow is the inverted carry for subtraction
    assign sum   = full[7:0];
    assign c_out = sub ? ~full[8] : full[8];
    assign h_out = sub ? ~half[4] : half[4];
    assign v_out = (a[7] == b_eff[7]) && (full[7] != a[7]);
endmodule
`default_nettype wire

//--- design/exec_pkg.sv
// shared constants and operation codes for the execution unit
package exec_pkg;

    // ********************************
    // flag bit positions in flags_word
    // ********************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ********************************
    // reset values and constants
    // ********************************
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  ALL_ONES  = 8'hff;
    localparam logic [7:0]  ALL_ZERO  = 8'h00;

    // ********************************
    // cycle counts per operation
    // ********************************
    localparam logic [2:0] CYC_ONE      = 3'h1;
    localparam logic [2:0] CYC_WORD     = 3'h2;
    localparam logic [2:0] CYC_MUL      = 3'h2;
    localparam logic [2:0] CYC_RELGOTO  = 3'h2;
    localparam logic [2:0] CYC_PTRGOTO  = 3'h2;
    localparam logic [2:0] CYC_ABSGOTO  = 3'h3;
    localparam logic [2:0] CYC_RELCALL  = 3'h4;
    localparam logic [2:0] CYC_PTRCALL  = 3'h4;
    localparam logic [2:0] CYC_ABSCALL  = 3'h5;
    localparam logic [2:0] CYC_RETURN   = 3'h5;
    localparam logic [2:0] CYC_BR_TAKEN = 3'h2;

    // ********************************
    // operation codes from decode
    // ********************************
    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_ADD_CARRY, OP_WORD_SUM, OP_SUB, OP_SUB_BORROW,
        OP_WORD_DIFF, OP_AND, OP_OR, OP_XOR, OP_ONES_INV, OP_TWOS_INV,
        OP_MASK_SET, OP_MASK_CLEAR, OP_PLUS_ONE, OP_MINUS_ONE, OP_ZM_CHECK,
        OP_ZERO_REG, OP_ALL_ONES, OP_MUL_U, OP_MUL_S, OP_MUL_SU, OP_FRACTION_PRODUCT_UNSIGNED_U,
        OP_FRACTION_PRODUCT_UNSIGNED_S, OP_FRACTION_PRODUCT_UNSIGNED_SU, OP_REL_GOTO, OP_PTR_GOTO, OP_ABS_GOTO,
        OP_REL_CALL, OP_PTR_CALL, OP_ABS_CALL, OP_SUB_EXIT, OP_INT_EXIT,
        OP_EQUAL_SKIP, OP_CMP, OP_CMP_BORROW, OP_REG_BIT_CLR_SKIP,
        OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLR_SKIP, OP_IO_BIT_SET_SKIP,
        OP_FLAG_SET_BRANCH, OP_FLAG_CLR_BRANCH, OP_SIGNED_GE, OP_SIGNED_LT
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } seq_e;

endpackage

//--- design/mul_unit.sv
// 8x8 multiplier with signed, mixed and fractional forms
`timescale 1ns/1ps
`default_nettype none
module mul_unit
    import exec_pkg::*;
(
    // operands and mode
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       a_signed,
    input  wire logic       b_signed,
    input  wire logic       frac,
    // results
    output logic [15:0]     prod,
    output logic            c_out
);
    // ********************************
    // sign-extended 9x9 product
    // ********************************
    wire logic signed [8:0]  ax  = {a_signed & a[7], a};
    wire logic signed [8:0]  bx  = {b_signed & b[7], b};
    wire logic signed [17:0] raw = ax * bx;

    // carry is bit 15 before the fractional shift
    assign c_out = raw[15];
    assign prod  = frac ? {raw[14:0], 1'b0} : raw[15:0];
endmodule
`default_nettype wire

//--- test/alu_branch_exec_tb.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module alu_branch_exec_tb
    import exec_pkg::*;
;
    typedef struct {logic [15:0] pc; logic [7:0] fl, fm; logic [15:0] d, dm;} note_s;
    logic ref_clk = 1'b0, nrst = 1'b0, issue = 1'b0, v;
    op_e op = OP_NOP;
    op_e brs [4] = '{OP_FLAG_SET_BRANCH, OP_FLAG_CLR_BRANCH, OP_SIGNED_GE, OP_SIGNED_LT};
    logic [7:0] rd_val = 8'h00, rr_val = 8'h00, tie8 = 8'h00, a, b, exp_fl = 8'h00;
    logic signed [11:0] offset = 12'sh000;
    logic [15:0] abs_addr = 16'h0000, z_ptr = 16'h0000, stack_pc = 16'h0000, exp_pc = 16'h0000, p;
    logic [2:0] sel = 3'h0;
    logic [7:0] wr_lo, wr_hi, flags_word, r0_ff, r1_ff;
    logic [8:0] s;
    logic [4:0] hs;
    logic wr_en, wr_pair, wr_mul, busy, done;
    logic [15:0] pc;
    int fails = 0, tests_run = 0;
    note_s notes[$], cur;
    always #5 ref_clk = ~ref_clk;
    alu_branch_exec dut (.ref_clk, .nrst, .issue, .op, .rd_val, .rr_val, .rd_hi_val(tie8),
        .imm(tie8), .sel, .offset, .abs_addr, .z_ptr, .stack_pc, .io_val(tie8),
        .next_is_long(1'b0), .wr_en, .wr_lo, .wr_hi, .wr_pair, .wr_mul, .flags_word, .pc,
        .busy, .done);
    regfile_model pair (.ref_clk, .nrst, .wr_mul, .wr_lo, .wr_hi, .r0_ff, .r1_ff);
    // ********
    // tasks
    // ********
    task automatic chk(input string what, input logic [15:0] e, m, g);
        tests_run++;
        if ((g & m) !== (e & m))
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e & m, g & m);
        end
    endtask
    // note expectation, issue, wait bounded time for done
    task automatic run(input op_e o, input logic [7:0] x, y, fm, input logic [15:0] d, dm);
        notes.push_back('{exp_pc, exp_fl, fm, d, dm});
        @(negedge ref_clk);
        op = o;
        rd_val = x;
        rr_val = y;
        issue = 1'b1;
        @(negedge ref_clk);
        issue = 1'b0;
        for (int i = 0; i < 8 && done !== 1'b1; i++) @(negedge ref_clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watcher: each done pulse retires the oldest note
    always @(negedge ref_clk)
        if (done === 1'b1)
        begin
            cur = notes.pop_front();
            chk("pc", cur.pc, 16'hffff, pc);
            chk("flags", {8'h00, cur.fl}, {8'h00, cur.fm}, {8'h00, flags_word});
            chk("data", cur.d, cur.dm, {wr_hi, wr_lo});
        end
    // watchdog: the sequence needs under a hundred cycles
    initial
    begin
        #50000;
        fails++;
        test_done();
    end
    // ********
    // main sequence
    // ********
    initial
    begin
        void'($urandom(51970));
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        // adds, the first at the signed overflow corner
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 0) ? 8'h80 : 8'($urandom);
            b = (i == 0) ? 8'h80 : 8'($urandom);
            s = a + b;
            hs = a[3:0] + b[3:0];
            v = (a[7] == b[7]) && (s[7] != a[7]);
            exp_fl[5:0] = {hs[4], s[7] ^ v, v, s[7], s[7:0] == 8'h00, s[8]};
            exp_pc++;
            run(OP_ADD, a, b, 8'h3f, {8'h00, s[7:0]}, 16'h00ff);
        end
        exp_pc++;
        exp_fl[3:1] = 3'b001;
        run(OP_AND, 8'hf0, 8'h0f, 8'h0f, 16'h0000, 16'h00ff);
        exp_pc++;
        run(OP_ALL_ONES, 8'h5a, 8'h00, 8'hef, 16'h00ff, 16'h00ff);
        // multiplies, a zero product first
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 0) ? 8'h00 : 8'($urandom);
            b = 8'($urandom);
            p = a * b;
            exp_fl[1:0] = {p == 16'h0000, p[15]};
            exp_pc++;
            run(OP_MUL_U, a, b, 8'h03, p, 16'hffff);
        end
        exp_pc++;
        exp_fl[1:0] = 2'b00;
        run(OP_FRACTION_PRODUCT_UNSIGNED_U, 8'h80, 8'h80, 8'h03, 16'h8000, 16'hffff);
        @(negedge ref_clk);
        chk("pair", 16'h8000, 16'hffff, {r1_ff, r0_ff});
        offset = -12'sd5;
        exp_pc = exp_pc - 16'h0004;
        run(OP_REL_GOTO, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
        z_ptr = 16'($urandom);
        exp_pc = z_ptr;
        run(OP_PTR_GOTO, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
        abs_addr = 16'($urandom);
        exp_pc = abs_addr;
        run(OP_ABS_CALL, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
        stack_pc = 16'($urandom);
        exp_pc = stack_pc;
        exp_fl[7] = 1'b1;
        run(OP_INT_EXIT, 8'h00, 8'h00, 8'h80, 16'h0000, 16'h0000);
        // I set, N xor V clear: even entries taken
        offset = 12'sd3;
        sel = 3'h7;
        for (int i = 0; i < 4; i++)
        begin
            exp_pc = exp_pc + ((i % 2 == 0) ? 16'h0004 : 16'h0001);
            run(brs[i], 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
        end
        repeat (3) @(negedge ref_clk);
        chk("pending", 16'h0000, 16'hffff, 16'(notes.size()));
        test_done();
    end
endmodule
bind alu_branch_exec exec_checks chk (.*);
`default_nettype wire

//--- test/exec_checks_assertions.sv
// timing and result checks on the execution unit ports
`timescale 1ns/1ps
`default_nettype none
module exec_checks
    import exec_pkg::*;
(
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               nrst,
    // request
    input wire logic               issue,
    input wire op_e                op,
    input wire logic [7:0]         rd_val,
    input wire logic [7:0]         rr_val,
    input wire logic [2:0]         sel,
    input wire logic signed [11:0] offset,
    input wire logic [15:0]        abs_addr,
    input wire logic [15:0]        z_ptr,
    input wire logic [15:0]        stack_pc,
    // results
    input wire logic               wr_en,
    input wire logic [7:0]         wr_lo,
    input wire logic [7:0]         wr_hi,
    input wire logic               wr_mul,
    input wire logic [7:0]         flags_word,
    input wire logic [15:0]        pc,
    input wire logic               busy,
    input wire logic               done
);
    // ********
    // properties
    // ********
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // a request counts only when the unit is free
    wire logic t = issue & ~busy;
    property p_add; t && op == OP_ADD |=> done && wr_en && wr_lo == 8'($past(rd_val) + $past(rr_val)); endproperty
    a_add: assert property (p_add) else $error("add result wrong");
    property p_and; t && op == OP_AND |=> !flags_word[FLAG_V] && flags_word[FLAG_C] == $past(flags_word[FLAG_C]); endproperty
    a_and: assert property (p_and) else $error("logic flags wrong");
    property p_ones; t && op == OP_ALL_ONES |=> wr_lo == 8'hff && $stable(flags_word); endproperty
    a_ones: assert property (p_ones) else $error("all ones load wrong");
    property p_mul; t && op == OP_MUL_U |=> busy ##1 done && wr_mul && {wr_hi, wr_lo} == $past(rd_val, 2) * $past(rr_val, 2); endproperty
    a_mul: assert property (p_mul) else $error("product wrong");
    property p_rel; t && op == OP_REL_GOTO |=> busy ##1 done && pc == $past(pc, 2) + $past(16'(offset), 2) + 16'h0001; endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_ptr; t && op == OP_PTR_GOTO |=> busy ##1 done && pc == $past(z_ptr, 2); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer target wrong");
    property p_call; t && op == OP_ABS_CALL |=> busy[*4] ##1 done && !busy && pc == $past(abs_addr, 5); endproperty
    a_call: assert property (p_call) else $error("absolute call wrong");
    property p_interrupt_exit; t && op == OP_INT_EXIT |=> busy[*4] ##1 done && flags_word[FLAG_I] && pc == $past(stack_pc, 5); endproperty
    a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt exit wrong");
    property p_brt; t && op == OP_FLAG_SET_BRANCH && flags_word[sel] |=> busy ##1 done && !busy; endproperty
    a_brt: assert property (p_brt) else $error("taken branch timing wrong");
    property p_ge; t && op == OP_SIGNED_GE && !(flags_word[FLAG_N] ^ flags_word[FLAG_V]) |=> busy; endproperty
    a_ge: assert property (p_ge) else $error("signed branch not taken");
    c_call: cover property (t && op == OP_ABS_CALL);
    c_mul: cover property (t && op == OP_MUL_U);
    c_brt: cover property (t && op == OP_FLAG_SET_BRANCH);
endmodule
`default_nettype wire

//--- test/regfile_model.sv
// register file model: keeps the r1:r0 product pair
`timescale 1ns/1ps
`default_nettype none
module regfile_model
(
    // clock and reset
    input wire logic  ref_clk,
    input wire logic  nrst,
    // write side
    input wire logic       wr_mul,
    input wire logic [7:0] wr_lo,
    input wire logic [7:0] wr_hi,
    // stored pair
    output logic [7:0]     r0_ff,
    output logic [7:0]     r1_ff
);
    // only a multiply write touches the pair, so stray pulses show up
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
            {r1_ff, r0_ff} <= 16'h0000;
        else if (wr_mul)
            {r1_ff, r0_ff} <= {wr_hi, wr_lo};
endmodule
`default_nettype wire
